// >>> hw/itc_pkg.sv
// Constants and types for the interval timer counting element
package itc_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [15:0] CE_RESET = 16'h0000;
  localparam logic [15:0] CR_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_TWO = 16'h0002;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_TWO = 2'h2;
  localparam logic [4:0] BCD_TEN = 5'h0A;
  localparam int BCD_DIGITS = 4;
  localparam logic OUT_RESET = 1'b1;

  // ==========================================================
  // Modes, count formats, sequencer states
  typedef enum logic [2:0] {
    ITC_MODE0 = 3'h0,
    ITC_MODE1 = 3'h1,
    ITC_MODE2 = 3'h2,
    ITC_MODE3 = 3'h3,
    ITC_MODE4 = 3'h4,
    ITC_MODE5 = 3'h5
  } itc_mode_t;

  localparam itc_mode_t MODE_RESET = ITC_MODE0;

  typedef enum logic [1:0] {
    ITC_FMT_LATCH = 2'h0,
    ITC_FMT_LSB = 2'h1,
    ITC_FMT_MSB = 2'h2,
    ITC_FMT_BOTH = 2'h3
  } itc_fmt_t;

  localparam itc_fmt_t FMT_RESET = ITC_FMT_LSB;

  typedef enum logic [2:0] {
    ITC_ST_IDLE = 3'b001,
    ITC_ST_WAIT = 3'b010,
    ITC_ST_RUN = 3'b100
  } itc_state_t;

  // ==========================================================
  // Host write port carried as one bundle
  typedef struct packed {
    logic ctl_wr;
    logic cnt_wr;
    logic [2:0] mode;
    itc_fmt_t fmt;
    logic bcd;
    logic [7:0] data;
  } itc_host_t;

endpackage

// >>> hw/itc_channel.sv
// One interval timer channel: counting element, gate and output logic
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - Clock pulse is rise then fall; gate rise triggers
// - Mode 0: control drops out, high after N+1
// - Mode 0: out stays high until rewritten
// - Mode 0: load with gate low, count later
// - Mode 0: first of two bytes halts, drops out
// - Mode 1: trigger loads, low N pulses
// - Mode 1: new count waits for retrigger
// - Mode 2: divide by N, one-pulse low
// - Mode 2: gate low forces high, trigger reloads
// - Mode 2: first low pulse N after write
// - Mode 2: new count at trigger or cycle end
// - Mode 3: square wave, gate low forces high
// - Mode 3: new count at trigger or half-end
// - Mode 3 even: step two, toggle at zero
// - Mode 3 odd: high (N+1)/2, low (N-1)/2
// - Mode 3 may start low after control
// - Mode 4: count write triggers, strobe after N+1
// - Mode 4: gate low at strobe holds low
// - Mode 4: two-byte count loads after second byte
// - Mode 5: gate rise retriggers, strobe after N+1
// - Load and decrement on fall; gate on rise
// - Control write resets logic, sets out immediately
// - One-shot modes wrap; periodic modes reload
module itc_channel
  import itc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cnt_clk_pin,
  input wire logic gate_pin,
  input wire itc_host_t host,
  output logic out,
  output logic [15:0] count_value
);

  // ==========================================================
  // Helpers
  function automatic itc_mode_t norm_mode(input logic [2:0] m);
    if (m[1]) begin
      return itc_mode_t'({1'b0, m[1:0]});
    end
    return itc_mode_t'(m);
  endfunction

  function automatic logic [15:0] cnt_dec(input logic [15:0] v, input logic [1:0] step,
                                          input logic b);
    logic [15:0] r;
    logic [4:0] dig;
    logic [1:0] brw;
    r = v;
    brw = step;
    if (!b) begin
      return v - {14'h0000, step};
    end
    for (int i = 0; i < BCD_DIGITS; i++) begin
      dig = {1'b0, v[i*4 +: 4]} - {3'h0, brw};
      if (dig[4]) begin
        r[i*4 +: 4] = 4'(dig + BCD_TEN);
        brw = STEP_ONE;
      end else begin
        r[i*4 +: 4] = dig[3:0];
        brw = 2'h0;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Pin synchronisers and clock-pulse edges
  logic [1:0] clk_sync;
  logic [1:0] gate_sync;
  logic clk_prev;
  logic clk_rise;
  logic clk_fall;
  logic gate_smp;
  logic trig_pend;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_sync <= 2'h0;
      gate_sync <= 2'h0;
      clk_prev <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], cnt_clk_pin};
      gate_sync <= {gate_sync[0], gate_pin};
      clk_prev <= clk_sync[1];
    end
  end

  assign clk_rise = clk_sync[1] & ~clk_prev;
  assign clk_fall = ~clk_sync[1] & clk_prev;

  // Gate level only changes at the rising edge of the counter clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gate_smp <= 1'b0;
    end else if (clk_rise) begin
      gate_smp <= gate_sync[1];
    end
  end

  // Trigger held from the rising edge until the falling edge that consumes it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_pend <= 1'b0;
    end else if (clk_rise && gate_sync[1] && !gate_smp) begin
      trig_pend <= 1'b1;
    end else if (clk_fall || host.ctl_wr) begin
      trig_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Count register
  itc_mode_t mode;
  itc_fmt_t fmt;
  logic bcd;
  logic [15:0] cr;
  logic cnt_ready;
  logic msb_next;
  logic byte_hold;
  logic first_byte;
  logic cnt_done;
  logic take;

  assign first_byte = host.cnt_wr && (fmt == ITC_FMT_BOTH) && !msb_next;
  assign cnt_done = host.cnt_wr && ((fmt != ITC_FMT_BOTH) || msb_next);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cr <= CR_RESET;
      cnt_ready <= 1'b0;
      msb_next <= 1'b0;
      byte_hold <= 1'b0;
    end else if (host.ctl_wr) begin
      cnt_ready <= 1'b0;
      msb_next <= 1'b0;
      byte_hold <= 1'b0;
    end else if (host.cnt_wr) begin
      case (fmt)
        ITC_FMT_LSB: begin
          cr <= {8'h00, host.data};
          cnt_ready <= 1'b1;
        end
        ITC_FMT_MSB: begin
          cr <= {host.data, 8'h00};
          cnt_ready <= 1'b1;
        end
        ITC_FMT_BOTH: begin
          if (!msb_next) begin
            cr[7:0] <= host.data;
            msb_next <= 1'b1;
            byte_hold <= (mode == ITC_MODE0);
          end else begin
            cr[15:8] <= host.data;
            msb_next <= 1'b0;
            byte_hold <= 1'b0;
            cnt_ready <= 1'b1;
          end
        end
        default: begin
          cnt_ready <= cnt_ready;
        end
      endcase
    end else if (take) begin
      cnt_ready <= 1'b0;
    end
  end

  // ==========================================================
  // Load and reload decisions
  itc_state_t state;
  logic [15:0] ce;
  logic out_q;
  logic cur_odd;
  logic odd_extra;
  logic load_now;
  logic half_end;
  logic cycle_end;
  logic is_periodic;

  assign is_periodic = (mode == ITC_MODE2) || (mode == ITC_MODE3);
  // Odd counts spend one extra pulse at zero while high
  assign half_end = odd_extra || ((ce == CNT_TWO) && !(out_q && cur_odd));

  always_comb begin
    case (mode)
      ITC_MODE0, ITC_MODE4: load_now = clk_fall && cnt_ready;
      ITC_MODE1, ITC_MODE5: load_now = clk_fall && trig_pend && (state != ITC_ST_IDLE);
      ITC_MODE2, ITC_MODE3: load_now = clk_fall && gate_smp
        && ((cnt_ready && (state == ITC_ST_WAIT)) || (trig_pend && (state != ITC_ST_IDLE)));
      default: load_now = 1'b0;
    endcase
    cycle_end = clk_fall && gate_smp && (state == ITC_ST_RUN) && !load_now
      && (((mode == ITC_MODE2) && (ce == CNT_ONE)) || ((mode == ITC_MODE3) && half_end));
    take = load_now || cycle_end;
  end

  // ==========================================================
  // Counting element, output and sequencer state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ITC_ST_IDLE;
      ce <= CE_RESET;
      out_q <= OUT_RESET;
      cur_odd <= 1'b0;
      odd_extra <= 1'b0;
      mode <= MODE_RESET;
      fmt <= FMT_RESET;
      bcd <= 1'b0;
    end else if (host.ctl_wr) begin
      mode <= norm_mode(host.mode);
      fmt <= host.fmt;
      bcd <= host.bcd;
      state <= ITC_ST_IDLE;
      odd_extra <= 1'b0;
      case (norm_mode(host.mode))
        ITC_MODE0: out_q <= 1'b0;
        // A repeated mode 3 control byte is what brings the output up
        ITC_MODE3: out_q <= (mode == ITC_MODE3);
        default: out_q <= 1'b1;
      endcase
    end else begin
      if (clk_fall) begin
        case (mode)
          ITC_MODE0, ITC_MODE4: begin
            if (load_now) begin
              ce <= cr;
              state <= ITC_ST_RUN;
              if (mode == ITC_MODE4) begin
                out_q <= 1'b1;
              end
            end else if ((state != ITC_ST_IDLE) && gate_smp && !byte_hold) begin
              ce <= cnt_dec(ce, STEP_ONE, bcd);
              if (mode == ITC_MODE0) begin
                if ((ce == CNT_ONE) && (state == ITC_ST_RUN)) begin
                  out_q <= 1'b1;
                end
              end else if ((ce == CNT_ONE) && (state == ITC_ST_RUN)) begin
                out_q <= 1'b0;
                state <= ITC_ST_WAIT;
              end else begin
                out_q <= 1'b1;
              end
            end
            // Gate low across the strobe leaves the output low
          end
          ITC_MODE1, ITC_MODE5: begin
            if (load_now) begin
              ce <= cr;
              state <= ITC_ST_RUN;
              out_q <= (mode == ITC_MODE5);
            end else if (state != ITC_ST_IDLE) begin
              ce <= cnt_dec(ce, STEP_ONE, bcd);
              if ((ce == CNT_ONE) && (state == ITC_ST_RUN)) begin
                state <= ITC_ST_WAIT;
                out_q <= (mode == ITC_MODE1);
              end else begin
                out_q <= (mode == ITC_MODE5) ? 1'b1 : out_q;
              end
            end
          end
          ITC_MODE2: begin
            if (load_now) begin
              ce <= cr;
              state <= ITC_ST_RUN;
              out_q <= 1'b1;
            end else if (cycle_end) begin
              ce <= cr;
              out_q <= 1'b1;
            end else if ((state == ITC_ST_RUN) && gate_smp) begin
              ce <= cnt_dec(ce, STEP_ONE, bcd);
              out_q <= (ce != CNT_TWO);
            end
          end
          ITC_MODE3: begin
            if (load_now) begin
              ce <= {cr[15:1], 1'b0};
              cur_odd <= cr[0];
              odd_extra <= 1'b0;
              state <= ITC_ST_RUN;
            end else if (cycle_end) begin
              out_q <= !out_q;
              ce <= {cr[15:1], 1'b0};
              cur_odd <= cr[0];
              odd_extra <= 1'b0;
            end else if ((state == ITC_ST_RUN) && gate_smp) begin
              if ((ce == CNT_TWO) && out_q && cur_odd) begin
                ce <= CE_RESET;
                odd_extra <= 1'b1;
              end else begin
                ce <= cnt_dec(ce, STEP_TWO, bcd);
              end
            end
          end
          default: begin
            state <= ITC_ST_IDLE;
          end
        endcase
      end
      // Gate seen low at a counter clock rise in the periodic modes forces the output high
      if (clk_rise && !gate_sync[1] && is_periodic) begin
        out_q <= 1'b1;
      end
      if (first_byte && (mode == ITC_MODE0)) begin
        out_q <= 1'b0;
      end
      if (cnt_done) begin
        if (mode == ITC_MODE0) begin
          out_q <= 1'b0;
        end
        if (state == ITC_ST_IDLE) begin
          state <= ITC_ST_WAIT;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_value <= CE_RESET;
    end else begin
      count_value <= ce;
    end
  end

  assign out = out_q;

  // ==========================================================
  // Assertions and cover points
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_CTL_M0_LOW: assert property (
    host.ctl_wr && (norm_mode(host.mode) == ITC_MODE0) |=> !out_q && (state == ITC_ST_IDLE))
    else $error("mode 0 control write did not drop the output");

  AST_M0_TC_HIGH: assert property (
    (mode == ITC_MODE0) && clk_fall && (state == ITC_ST_RUN) && gate_smp && !byte_hold
    && !load_now && (ce == CNT_ONE) && !host.ctl_wr && !host.cnt_wr |=> out_q)
    else $error("mode 0 output did not rise at terminal count");

  AST_M0_HOLD: assert property (
    (mode == ITC_MODE0) && out_q && !host.ctl_wr && !host.cnt_wr |=> out_q)
    else $error("mode 0 output fell without a write");

  AST_M0_FIRST_BYTE: assert property (
    (mode == ITC_MODE0) && first_byte && !host.ctl_wr |=> !out_q && byte_hold)
    else $error("first count byte did not halt mode 0");

  AST_LOAD_NO_DEC: assert property (
    load_now && !host.ctl_wr && !is_periodic |=> ce == $past(cr))
    else $error("load pulse also decremented the count");

  AST_M1_LOW: assert property (
    (mode == ITC_MODE1) && load_now && !host.ctl_wr |=> !out_q && (state == ITC_ST_RUN))
    else $error("one-shot did not start after trigger");

  AST_M2_LOW_ONE: assert property (
    (mode == ITC_MODE2) && clk_fall && gate_smp && (state == ITC_ST_RUN) && !load_now
    && (ce == CNT_TWO) && !host.ctl_wr |=> !out_q && (ce == CNT_ONE))
    else $error("rate generator low pulse missing");

  AST_GATE_FORCE_HIGH: assert property (
    is_periodic && clk_rise && !gate_sync[1] && !host.ctl_wr |=> out_q)
    else $error("gate low did not force output high");

  AST_M4_STROBE: assert property (
    (mode == ITC_MODE4) && clk_fall && (state == ITC_ST_RUN) && gate_smp && !load_now
    && !byte_hold && (ce == CNT_ONE) && !host.ctl_wr |=> !out_q)
    else $error("software strobe missing at terminal count");

  AST_M5_STROBE: assert property (
    (mode == ITC_MODE5) && clk_fall && (state == ITC_ST_RUN) && !load_now
    && (ce == CNT_ONE) && !host.ctl_wr |=> !out_q ##1 (state == ITC_ST_WAIT))
    else $error("hardware strobe missing at terminal count");

  COV_M2_PULSE: cover property ((mode == ITC_MODE2) && $fell(out_q));
  COV_M3_TOGGLE: cover property ((mode == ITC_MODE3) && cycle_end && !cur_odd);
  COV_M3_ODD: cover property ((mode == ITC_MODE3) && odd_extra);
  COV_M5_RETRIG: cover property ((mode == ITC_MODE5) && load_now && (state == ITC_ST_RUN));

endmodule

// >>> verification/itc_host_model.sv
// Host side model: writes control bytes and count bytes to one channel
`timescale 1ns/1ps
module itc_host_model
  import itc_pkg::*;
(
  input wire logic ref_clk,
  output itc_host_t host
);
  initial begin
    host = '0;
    host.fmt = ITC_FMT_LSB;
  end

  // ==========================================================
  // Write cycles
  // Modes 1 and 5 are never asked for with a latch format
  // Raw mode field, so the x1x aliases of modes 2 and 3 can be sent too
  task automatic ctl(input logic [2:0] m, input itc_fmt_t f, input logic b = 1'b0);
    @(negedge ref_clk);
    host.mode = m;
    host.fmt = f;
    host.bcd = b;
    host.ctl_wr = 1'b1;
    @(negedge ref_clk);
    host.ctl_wr = 1'b0;
  endtask

  // High start in mode 3 is had by writing its control byte twice
  task automatic ctl3_high(input itc_fmt_t f);
    ctl(ITC_MODE3, f);
    ctl(ITC_MODE3, f);
  endtask

  task automatic cnt(input logic [7:0] d);
    @(negedge ref_clk);
    host.data = d;
    host.cnt_wr = 1'b1;
    @(negedge ref_clk);
    host.cnt_wr = 1'b0;
    // Released data is stale; show its inverse so a late capture shows
    host.data = ~d;
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the interval timer channel
`timescale 1ns/1ps
module tb_top
  import itc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cnt_clk_pin = 1'b0;
  logic gate_pin = 1'b1;
  itc_host_t host;
  logic out;
  logic [15:0] count_value;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2 ref_clk = ~ref_clk;

  itc_host_model u_host (.ref_clk(ref_clk), .host(host));

  itc_channel u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .cnt_clk_pin(cnt_clk_pin),
    .gate_pin(gate_pin),
    .host(host),
    .out(out),
    .count_value(count_value)
  );

  // ==========================================================
  // Compare and drive helpers
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  // Each level held well past the three-cycle minimum so both edges are seen
  task automatic pulse();
    @(negedge ref_clk);
    cnt_clk_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    cnt_clk_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic run(input int n, input logic [7:0] e);
    for (int i = 0; i < n; i++) begin
      pulse();
      chk_bit("out", e[i], out);
    end
  endtask

  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic set_gate(input logic v);
    @(negedge ref_clk);
    gate_pin = v;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic highs(input int n, output int h);
    h = 0;
    for (int i = 0; i < n; i++) begin
      pulse();
      if (out === 1'b1) h++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_mode0();
    u_host.ctl(ITC_MODE0, ITC_FMT_LSB);
    settle();
    chk_bit("out", 1'b0, out);
    u_host.cnt(8'h02);
    run(1, 8'h00);
    chk_word("count_value", 16'h0002, count_value);
    run(4, 8'h0E);
    chk_word("count_value", 16'hFFFE, count_value);
    $display("test mode0 done");
  endtask

  task automatic t_mode0_gate();
    set_gate(1'b0);
    u_host.ctl(ITC_MODE0, ITC_FMT_LSB);
    u_host.cnt(8'h02);
    run(3, 8'h00);
    chk_word("count_value", 16'h0002, count_value);
    set_gate(1'b1);
    run(2, 8'h02);
    $display("test mode0 gate done");
  endtask

  task automatic t_mode0_two();
    u_host.ctl(ITC_MODE0, ITC_FMT_BOTH);
    u_host.cnt(8'h01);
    u_host.cnt(8'h00);
    run(2, 8'h02);
    u_host.cnt(8'h03);
    settle();
    chk_bit("out", 1'b0, out);
    run(2, 8'h00);
    u_host.cnt(8'h00);
    run(4, 8'h08);
    $display("test mode0 two byte done");
  endtask

  task automatic t_mode1();
    set_gate(1'b0);
    u_host.ctl(ITC_MODE1, ITC_FMT_LSB);
    u_host.cnt(8'h02);
    run(2, 8'h03);
    set_gate(1'b1);
    run(3, 8'h04);
    set_gate(1'b0);
    run(2, 8'h03);
    set_gate(1'b1);
    run(1, 8'h00);
    u_host.cnt(8'h03);
    run(2, 8'h02);
    set_gate(1'b0);
    // Gate is only sampled on a counter clock rise, so a low must see a pulse
    pulse();
    set_gate(1'b1);
    run(4, 8'h08);
    $display("test mode1 done");
  endtask

  task automatic t_mode2();
    u_host.ctl(ITC_MODE2, ITC_FMT_LSB);
    u_host.cnt(8'h03);
    run(6, 8'h1B);
    set_gate(1'b0);
    run(1, 8'h01);
    set_gate(1'b1);
    run(3, 8'h03);
    u_host.cnt(8'h02);
    run(3, 8'h05);
    $display("test mode2 done");
  endtask

  task automatic t_mode3();
    int h;
    u_host.ctl(ITC_MODE3, ITC_FMT_LSB);
    settle();
    chk_bit("out", 1'b0, out);
    u_host.ctl3_high(ITC_FMT_LSB);
    settle();
    chk_bit("out", 1'b1, out);
    u_host.cnt(8'h04);
    repeat (2) pulse();
    highs(20, h);
    chk_word("high pulses", 16'h000A, 16'(h));
    u_host.ctl3_high(ITC_FMT_LSB);
    u_host.cnt(8'h05);
    repeat (2) pulse();
    highs(20, h);
    chk_word("high pulses", 16'h000C, 16'(h));
    $display("test mode3 done");
  endtask

  task automatic t_mode4();
    u_host.ctl(ITC_MODE4, ITC_FMT_LSB);
    settle();
    chk_bit("out", 1'b1, out);
    u_host.cnt(8'h02);
    run(5, 8'h1B);
    u_host.ctl(ITC_MODE4, ITC_FMT_BOTH);
    u_host.cnt(8'h02);
    u_host.cnt(8'h00);
    run(4, 8'h0B);
    $display("test mode4 done");
  endtask

  task automatic t_mode5();
    set_gate(1'b0);
    u_host.ctl(ITC_MODE5, ITC_FMT_LSB);
    u_host.cnt(8'h01);
    run(2, 8'h03);
    for (int k = 0; k < 2; k++) begin
      set_gate(1'b1);
      run(3, 8'h05);
      set_gate(1'b0);
      pulse();
    end
    $display("test mode5 done");
  endtask

  task automatic t_alias_bcd();
    set_gate(1'b1);
    u_host.ctl(3'h6, ITC_FMT_MSB);
    u_host.cnt(8'h01);
    run(2, 8'h03);
    chk_word("count_value", 16'h00FF, count_value);
    u_host.ctl(ITC_MODE0, ITC_FMT_LSB, 1'b1);
    u_host.cnt(8'h01);
    run(3, 8'h06);
    chk_word("count_value", 16'h9999, count_value);
    $display("test alias bcd done");
  endtask

  // ==========================================================
  // Verdict and hang guard
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs about 1400 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_bit("out", 1'b1, out);
    t_mode0();
    t_mode0_gate();
    t_mode0_two();
    t_mode1();
    t_mode2();
    t_mode3();
    t_mode4();
    t_mode5();
    t_alias_bcd();
    wrap_up();
  end
endmodule
